// ### rtl/dao_regs.svh
// Register map, fields, reset values and behaviour list.
//
// Behaviour
// R01 - One shared encode edge captures both channels.
// R02 - A 12-bit word per channel; top bit is the MSB.
// R03 - Formats: full rate, DDR single-ended, DDR differential.
// R04 - Full rate: outputs change on the data clock fall.
// R05 - Complement data clock is the inverse of the true one.
// R06 - A mode setting delays the data clock against the data.
// R07 - Full rate: range flag high for an out-of-range sample.
// R08 - DDR: data change on both data clock edges.
// R09 - DDR: even bit while clock low, odd bit while high.
// R10 - Differential DDR: six pairs per channel, same pairing.
// R11 - DDR: shared range flag is channel 2 low, channel 1 high.
// R12 - DDR single-ended: receiver leaves odd-position outputs open.
// R13 - Differential format: programmable drive current.
// R14 - Differential format: optional internal pair termination.
// R15 - A mode register write selects format and features.
// R16 - Conversion starts on the true encode rising edge.
// R17 - Strapped configuration offers no DDR single-ended format.
// R18 - Receiver captures opposite the change edge, minding delay.
`ifndef DAO_REGS_SVH
`define DAO_REGS_SVH

`define DAO_ADDR_W 8
`define DAO_MODE_ADDR 8'h00
`define DAO_STATUS_ADDR 8'h04
`define DAO_MASK_ADDR 8'h08
`define DAO_SAMPLE_ADDR 8'h0C
`define DAO_INFO_ADDR 8'h10

`define DAO_FMT_LSB 0
`define DAO_FMT_W 2
`define DAO_PHASE_LSB 2
`define DAO_PHASE_W 2
`define DAO_DRIVE_LSB 4
`define DAO_DRIVE_W 3
`define DAO_TERM_BIT 7
`define DAO_PHASE_RESET 2'h0
`define DAO_DRIVE_RESET 3'h4
`define DAO_TERM_RESET 1'h0

`define DAO_EV_W 4
`define DAO_EV_SAMPLE 0
`define DAO_EV_RANGE1 1
`define DAO_EV_RANGE2 2
`define DAO_EV_REFUSED 3

`define DAO_SAMPLE_W 12
`define DAO_S1_LSB 0
`define DAO_S1OF_BIT 12
`define DAO_S2_LSB 16
`define DAO_S2OF_BIT 28
`define DAO_INFO_STRAP_BIT 2

`define DAO_PHASE_TAPS 3

`endif

// ### rtl/dao_pkg.sv
// Types and shared helpers of the output interface.
`default_nettype none

package dao_pkg;

    typedef enum logic [1:0] {
        FMT_FULL = 2'h0,
        FMT_DDR_CMOS = 2'h1,
        FMT_DDR_LVDS = 2'h2
    } dao_format_type;

    // Picks the even or the odd half of a sample word for one DDR phase.
    function automatic logic [5:0] dao_pick_half(
        input logic [11:0] word,
        input logic odd
    );
        logic [5:0] half;
        half = 6'h00;
        for (int i = 0; i < 6; i++)
        begin
            half[i] = odd ? word[2 * i + 1] : word[2 * i];
        end
        return half;
    endfunction

endpackage

`default_nettype wire

// ### rtl/dao_pin_sync.sv
// Three-stage pin synchroniser with agreement of stages two and three.
`default_nettype none

module dao_pin_sync #(
    parameter int W = 3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinOut
);

    generate
        if (W < 1)
        begin : gBadWidth
            $error("dao_pin_sync needs at least one pin");
        end
    endgenerate

    logic [W-1:0] s1_r, s2_r, s3_r, out_r;
    logic [W-1:0] out_nxt;

    // The first stage feeds only the second one.
    always_comb
    begin
        out_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & out_r);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end
        else
        begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign pinOut = out_r;

endmodule

`default_nettype wire

// ### rtl/dao_clock_delay.sv
// Tap delay line that shifts the forwarded data clock against the data.
`default_nettype none

module dao_clock_delay #(
    parameter int MAX_TAPS = 3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic levelIn,
    input wire logic [$clog2(MAX_TAPS+1)-1:0] tapSel,
    output logic levelOut
);

    generate
        if (MAX_TAPS < 2)
        begin : gBadTaps
            $error("dao_clock_delay needs at least two taps");
        end
    endgenerate

    logic [MAX_TAPS:1] sh_r, sh_nxt;
    logic [MAX_TAPS:0] taps;

    always_comb
    begin
        sh_nxt = {sh_r[MAX_TAPS-1:1], levelIn};
        taps = {sh_r, levelIn};
        // Tap zero is the already registered clock level itself.
        if (int'(tapSel) > MAX_TAPS)
        begin
            levelOut = taps[MAX_TAPS];
        end
        else
        begin
            levelOut = taps[tapSel];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sh_r <= '0;
        end
        else
        begin
            sh_r <= sh_nxt;
        end
    end

endmodule

`default_nettype wire

// ### rtl/dao_output_interface.sv
// Two-channel sample output interface with a register port.
`include "dao_regs.svh"
`default_nettype none

module dao_output_interface (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [`DAO_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [31:0] regRdData,
    output logic irq,
    input wire logic encode_clock_p,
    input wire logic encode_clock_n,
    input wire logic config_method_strap,
    input wire logic [`DAO_SAMPLE_W-1:0] ch1ConvCode,
    input wire logic ch1ConvOver,
    input wire logic [`DAO_SAMPLE_W-1:0] ch2ConvCode,
    input wire logic ch2ConvOver,
    output logic fwd_data_clock_p,
    output logic fwd_data_clock_n,
    output logic [`DAO_SAMPLE_W-1:0] ch1_sample_bits,
    output logic [`DAO_SAMPLE_W-1:0] ch2_sample_bits,
    output logic ch1_range_flag,
    output logic ch2_range_flag,
    output logic [5:0] ch1_paired_bits,
    output logic [5:0] ch2_paired_bits,
    output logic [5:0] ch1PairedComp,
    output logic [5:0] ch2PairedComp,
    output logic shared_range_flag,
    output logic sharedRangeComp,
    output logic lvdsEnable,
    output logic [`DAO_DRIVE_W-1:0] lvdsDriveCode,
    output logic lvdsTermEnable
);

    // ==========================================================
    // Pin synchronisation and encode edges
    // ==========================================================

    logic [2:0] pinSync;
    logic encLevel;
    logic strapSync;
    logic riseEv;
    logic fallEv;
    logic encPrev_r;

    dao_pin_sync #(
        .W(3)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pinIn({config_method_strap, encode_clock_n, encode_clock_p}),
        .pinOut(pinSync)
    );

    // A grounded complement means single-ended encode;
    // both encode modes reduce to this level.
    assign encLevel = pinSync[0] & ~pinSync[1];
    assign strapSync = pinSync[2];
    assign riseEv = encLevel & ~encPrev_r; // R16
    assign fallEv = ~encLevel & encPrev_r;

    // ==========================================================
    // Mode, status and mask registers
    // ==========================================================

    dao_pkg::dao_format_type fmt_r, fmt_nxt;
    dao_pkg::dao_format_type effFmt;
    logic [`DAO_PHASE_W-1:0] phase_r, phase_nxt;
    logic [`DAO_DRIVE_W-1:0] drive_r, drive_nxt;
    logic term_r, term_nxt;
    logic [`DAO_EV_W-1:0] status_r, status_nxt;
    logic [`DAO_EV_W-1:0] mask_r, mask_nxt;
    logic [`DAO_EV_W-1:0] events;
    logic [`DAO_EV_W-1:0] statusClr;
    logic [31:0] rdData_r, rdData_nxt;
    logic [`DAO_FMT_W-1:0] reqFmt;
    logic isDdr;
    logic lvdsOn;

    // Strapped parts fall back from DDR single-ended to full rate, even if the
    // register was loaded before the strap settled.
    always_comb
    begin
        if (strapSync && fmt_r == dao_pkg::FMT_DDR_CMOS)
        begin
            effFmt = dao_pkg::FMT_FULL; // R17
        end
        else
        begin
            effFmt = fmt_r;
        end
    end

    assign isDdr = (effFmt != dao_pkg::FMT_FULL);
    assign lvdsOn = (effFmt == dao_pkg::FMT_DDR_LVDS);

    logic [`DAO_SAMPLE_W-1:0] conv1_r, conv2_r;
    logic conv1Of_r, conv2Of_r;

    always_comb
    begin
        fmt_nxt = fmt_r;
        phase_nxt = phase_r;
        drive_nxt = drive_r;
        term_nxt = term_r;
        mask_nxt = mask_r;
        rdData_nxt = 32'h0000_0000;
        reqFmt = regWrData[`DAO_FMT_LSB +: `DAO_FMT_W];
        events = '0;
        events[`DAO_EV_SAMPLE] = riseEv;
        events[`DAO_EV_RANGE1] = riseEv & ch1ConvOver;
        events[`DAO_EV_RANGE2] = riseEv & ch2ConvOver;
        statusClr = '0;
        if (regWrEn)
        begin
            unique case (regAddr)
                `DAO_MODE_ADDR:
                begin
                    phase_nxt = regWrData[`DAO_PHASE_LSB +: `DAO_PHASE_W]; // R06
                    drive_nxt = regWrData[`DAO_DRIVE_LSB +: `DAO_DRIVE_W]; // R13
                    term_nxt = regWrData[`DAO_TERM_BIT]; // R14
                    // An illegal or unavailable format leaves the old one.
                    if (reqFmt == 2'h3
                        || (strapSync && reqFmt == 2'h1))
                    begin
                        events[`DAO_EV_REFUSED] = 1'b1; // R17
                    end
                    else
                    begin
                        fmt_nxt = dao_pkg::dao_format_type'(reqFmt); // R15
                    end
                end
                `DAO_STATUS_ADDR:
                begin
                    statusClr = regWrData[`DAO_EV_W-1:0];
                end
                `DAO_MASK_ADDR:
                begin
                    mask_nxt = regWrData[`DAO_EV_W-1:0];
                end
                default:
                begin
                end
            endcase
        end
        // A new event wins over a clear in the same cycle.
        status_nxt = (status_r & ~statusClr) | events;
        if (regRdEn)
        begin
            unique case (regAddr)
                `DAO_MODE_ADDR:
                begin
                    rdData_nxt[`DAO_FMT_LSB +: `DAO_FMT_W] = fmt_r;
                    rdData_nxt[`DAO_PHASE_LSB +: `DAO_PHASE_W] = phase_r;
                    rdData_nxt[`DAO_DRIVE_LSB +: `DAO_DRIVE_W] = drive_r;
                    rdData_nxt[`DAO_TERM_BIT] = term_r;
                end
                `DAO_STATUS_ADDR:
                begin
                    rdData_nxt[`DAO_EV_W-1:0] = status_r;
                end
                `DAO_MASK_ADDR:
                begin
                    rdData_nxt[`DAO_EV_W-1:0] = mask_r;
                end
                `DAO_SAMPLE_ADDR:
                begin
                    rdData_nxt[`DAO_S1_LSB +: `DAO_SAMPLE_W] = conv1_r;
                    rdData_nxt[`DAO_S1OF_BIT] = conv1Of_r;
                    rdData_nxt[`DAO_S2_LSB +: `DAO_SAMPLE_W] = conv2_r;
                    rdData_nxt[`DAO_S2OF_BIT] = conv2Of_r;
                end
                `DAO_INFO_ADDR:
                begin
                    rdData_nxt[`DAO_FMT_LSB +: `DAO_FMT_W] = effFmt;
                    rdData_nxt[`DAO_INFO_STRAP_BIT] = strapSync;
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            fmt_r <= dao_pkg::FMT_FULL;
            phase_r <= `DAO_PHASE_RESET;
            drive_r <= `DAO_DRIVE_RESET;
            term_r <= `DAO_TERM_RESET;
            status_r <= '0;
            mask_r <= '0;
            rdData_r <= 32'h0000_0000;
        end
        else
        begin
            fmt_r <= fmt_nxt;
            phase_r <= phase_nxt;
            drive_r <= drive_nxt;
            term_r <= term_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            rdData_r <= rdData_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign irq = |(status_r & mask_r);

    // ==========================================================
    // Sample capture and output formatting
    // ==========================================================

    logic [`DAO_SAMPLE_W-1:0] conv1_nxt, conv2_nxt;
    logic conv1Of_nxt, conv2Of_nxt;
    logic [`DAO_SAMPLE_W-1:0] held1_r, held1_nxt;
    logic [`DAO_SAMPLE_W-1:0] held2_r, held2_nxt;
    logic held1Of_r, held1Of_nxt;
    logic [`DAO_SAMPLE_W-1:0] fr1_r, fr1_nxt, fr2_r, fr2_nxt;
    logic frOf1_r, frOf1_nxt, frOf2_r, frOf2_nxt;
    logic [5:0] pr1_r, pr1_nxt, pr2_r, pr2_nxt;
    logic prOf_r, prOf_nxt;

    always_comb
    begin
        conv1_nxt = conv1_r;
        conv2_nxt = conv2_r;
        conv1Of_nxt = conv1Of_r;
        conv2Of_nxt = conv2Of_r;
        held1_nxt = held1_r;
        held2_nxt = held2_r;
        held1Of_nxt = held1Of_r;
        fr1_nxt = isDdr ? '0 : fr1_r;
        fr2_nxt = isDdr ? '0 : fr2_r;
        frOf1_nxt = isDdr ? 1'b0 : frOf1_r;
        frOf2_nxt = isDdr ? 1'b0 : frOf2_r;
        pr1_nxt = isDdr ? pr1_r : 6'h00;
        pr2_nxt = isDdr ? pr2_r : 6'h00;
        prOf_nxt = isDdr ? prOf_r : 1'b0;
        // One shared edge loads both channels in the same cycle.
        if (riseEv)
        begin
            conv1_nxt = ch1ConvCode; // R01
            conv2_nxt = ch2ConvCode; // R01
            conv1Of_nxt = ch1ConvOver;
            conv2Of_nxt = ch2ConvOver;
            if (isDdr)
            begin
                pr1_nxt = dao_pkg::dao_pick_half(held1_r, 1'b1); // R08
                pr2_nxt = dao_pkg::dao_pick_half(held2_r, 1'b1); // R09
                prOf_nxt = held1Of_r; // R11
            end
        end
        if (fallEv)
        begin
            held1_nxt = conv1_r;
            held2_nxt = conv2_r;
            held1Of_nxt = conv1Of_r;
            if (isDdr)
            begin
                pr1_nxt = dao_pkg::dao_pick_half(conv1_r, 1'b0); // R09
                pr2_nxt = dao_pkg::dao_pick_half(conv2_r, 1'b0); // R10
                prOf_nxt = conv2Of_r; // R11
            end
            else
            begin
                fr1_nxt = conv1_r; // R04
                fr2_nxt = conv2_r; // R02
                frOf1_nxt = conv1Of_r; // R07
                frOf2_nxt = conv2Of_r; // R07
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            encPrev_r <= 1'b0;
            conv1_r <= '0;
            conv2_r <= '0;
            conv1Of_r <= 1'b0;
            conv2Of_r <= 1'b0;
            held1_r <= '0;
            held2_r <= '0;
            held1Of_r <= 1'b0;
            fr1_r <= '0;
            fr2_r <= '0;
            frOf1_r <= 1'b0;
            frOf2_r <= 1'b0;
            pr1_r <= 6'h00;
            pr2_r <= 6'h00;
            prOf_r <= 1'b0;
        end
        else
        begin
            encPrev_r <= encLevel;
            conv1_r <= conv1_nxt;
            conv2_r <= conv2_nxt;
            conv1Of_r <= conv1Of_nxt;
            conv2Of_r <= conv2Of_nxt;
            held1_r <= held1_nxt;
            held2_r <= held2_nxt;
            held1Of_r <= held1Of_nxt;
            fr1_r <= fr1_nxt;
            fr2_r <= fr2_nxt;
            frOf1_r <= frOf1_nxt;
            frOf2_r <= frOf2_nxt;
            pr1_r <= pr1_nxt;
            pr2_r <= pr2_nxt;
            prOf_r <= prOf_nxt;
        end
    end

    // ==========================================================
    // Forwarded clock and pins
    // ==========================================================

    // The registered encode level moves with the data,
    // so with no delay both change on one edge.
    dao_clock_delay #(
        .MAX_TAPS(`DAO_PHASE_TAPS)
    ) u_clock_delay (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .levelIn(encPrev_r),
        .tapSel(phase_r), // R06
        .levelOut(fwd_data_clock_p)
    );

    assign fwd_data_clock_n = ~fwd_data_clock_p; // R05
    assign ch1_sample_bits = fr1_r;
    assign ch2_sample_bits = fr2_r;
    assign ch1_range_flag = frOf1_r;
    assign ch2_range_flag = frOf2_r;
    assign ch1_paired_bits = pr1_r;
    assign ch2_paired_bits = pr2_r;
    assign shared_range_flag = prOf_r;
    // In single-ended DDR the complement lines are idle and left open.
    assign ch1PairedComp = lvdsOn ? ~pr1_r : 6'h00; // R10
    assign ch2PairedComp = lvdsOn ? ~pr2_r : 6'h00; // R10
    assign sharedRangeComp = lvdsOn ? ~prOf_r : 1'b0;
    assign lvdsEnable = lvdsOn; // R03
    assign lvdsDriveCode = drive_r; // R13
    assign lvdsTermEnable = lvdsOn & term_r; // R14

    // ==========================================================
    // Checks
    // ==========================================================

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    both_capture_a: assert property ( // R01
        riseEv |=> conv1_r == $past(ch1ConvCode)
            && conv2_r == $past(ch2ConvCode))
        else $error("channels not captured together");

    msb_place_a: assert property ( // R02
        fallEv && !isDdr |=> ch1_sample_bits[11] == $past(conv1_r[11])
            && ch2_sample_bits[11] == $past(conv2_r[11]))
        else $error("sample MSB misplaced");

    full_fall_a: assert property ( // R04
        fallEv && !isDdr |=> !encPrev_r && ch1_sample_bits == $past(conv1_r))
        else $error("full-rate data not moved on falling edge");

    clock_comp_a: assert property ( // R05
        $rose(fwd_data_clock_p) |-> $fell(fwd_data_clock_n))
        else $error("clock complement not inverse");

    phase_delay_a: assert property ( // R06
        phase_r == 2'h2 && $past(phase_r) == 2'h2
            && $past(phase_r, 2) == 2'h2
            |-> fwd_data_clock_p == $past(encPrev_r, 2))
        else $error("clock delay tap wrong");

    range_flag_a: assert property ( // R07
        fallEv && !isDdr |=> ch1_range_flag == $past(conv1Of_r)
            && ch2_range_flag == $past(conv2Of_r))
        else $error("full-rate range flag wrong");

    ddr_rise_a: assert property ( // R08
        riseEv && isDdr |=> ch1_paired_bits
            == dao_pkg::dao_pick_half($past(held1_r), 1'b1))
        else $error("odd bits not shown on rising edge");

    ddr_even_a: assert property ( // R09
        fallEv && isDdr |=> ch2_paired_bits
            == dao_pkg::dao_pick_half($past(conv2_r), 1'b0))
        else $error("even bits not shown on falling edge");

    shared_flag_a: assert property ( // R11
        fallEv && isDdr ##1 (!riseEv)[*2] |-> shared_range_flag
            == $past(conv2Of_r, 3))
        else $error("shared flag not channel 2 while low");

    strap_format_a: assert property ( // R17
        strapSync |-> effFmt != dao_pkg::FMT_DDR_CMOS)
        else $error("DDR single-ended active while strapped");

    mode_write_a: assert property ( // R15
        regWrEn && regAddr == `DAO_MODE_ADDR && regWrData[1:0] == 2'h2
            |=> fmt_r == dao_pkg::FMT_DDR_LVDS ##1 lvdsEnable)
        else $error("format write not applied");

    lvds_term_a: assert property ( // R14
        lvdsTermEnable |-> lvdsOn && term_r && lvdsDriveCode == drive_r)
        else $error("termination outside differential format");

endmodule

`default_nettype wire

// ### tb/dao_rx_model.sv
// Capture receiver model that rebuilds sample words from the output pins.
`default_nettype none

module dao_rx_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ddrMode,
    input wire logic clkP,
    input wire logic [11:0] ch1Full,
    input wire logic [11:0] ch2Full,
    input wire logic ch1Flag,
    input wire logic ch2Flag,
    input wire logic [5:0] ch1Lane,
    input wire logic [5:0] ch2Lane,
    input wire logic sharedFlag,
    output logic rxValid,
    output logic [31:0] rxWord,
    output logic [3:0] rxLag
);
    timeunit 1ns;
    timeprecision 1ps;

    logic clkPrev, flag2;
    logic [38:0] seen, seenPrev;
    logic [3:0] quiet;
    logic [5:0] even1, even2;
    logic [11:0] w1, w2;

    assign seen = {ch1Full, ch2Full, ch1Flag, ch2Flag, ch1Lane, ch2Lane,
        sharedFlag};

    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            w1[2 * i] = even1[i];
            w1[2 * i + 1] = ch1Lane[i];
            w2[2 * i] = even2[i];
            w2[2 * i + 1] = ch2Lane[i];
        end
    end

    // Capture one cycle after a seen clock edge, clear of early data.
    always @(posedge ref_clk)
    begin
        clkPrev <= clkP;
        seenPrev <= seen;
        quiet <= (seen != seenPrev) ? 4'h0 : quiet + 4'h1;
        rxValid <= 1'b0;
        if (rst_n && clkP != clkPrev)
        begin
            if (!clkP)
            begin
                rxLag <= (seen != seenPrev) ? 4'h0 : quiet + 4'h1;
                even1 <= ch1Lane;
                even2 <= ch2Lane;
                flag2 <= sharedFlag;
            end
            else
            begin
                rxValid <= 1'b1;
                rxWord <= ddrMode ? {3'h0, flag2, w2, 3'h0, sharedFlag, w1}
                    : {3'h0, ch2Flag, ch2Full, 3'h0, ch1Flag, ch1Full};
            end
        end
    end
endmodule

`default_nettype wire

// ### tb/dao_output_interface_tb.sv
// Self-checking bench of the two-channel output interface.
`default_nettype none

module dao_output_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk, rst_n, regWrEn, regRdEn, irq, encode_clock_p;
    logic encode_clock_n, config_method_strap, ch1ConvOver, ch2ConvOver;
    logic fwd_data_clock_p, fwd_data_clock_n, ch1_range_flag;
    logic ch2_range_flag, shared_range_flag, sharedRangeComp, lvdsEnable;
    logic lvdsTermEnable, rxValid, ddrMode, hold, synced;
    logic [7:0] regAddr;
    logic [31:0] regWrData, regRdData, rxWord, rdv, mode, front;
    logic [11:0] ch1ConvCode, ch2ConvCode, ch1_sample_bits, ch2_sample_bits;
    logic [5:0] ch1_paired_bits, ch2_paired_bits, ch1PairedComp, ch2PairedComp;
    logic [12:0] lv, lc;
    logic [2:0] lvdsDriveCode;
    logic [3:0] rxLag;
    int error_cnt, n_tests, goodCnt, curFmt, curTaps, idx, k;
    int expQ[$];
    logic [31:0] cfg [5] = '{32'h00000040, 32'h0000002C, 32'h000000F5,
        32'h000000AA, 32'h00000062};

    dao_output_interface uut (
        .ref_clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn,
        .regRdData, .irq, .encode_clock_p, .encode_clock_n,
        .config_method_strap, .ch1ConvCode, .ch1ConvOver, .ch2ConvCode,
        .ch2ConvOver, .fwd_data_clock_p, .fwd_data_clock_n, .ch1_sample_bits,
        .ch2_sample_bits, .ch1_range_flag, .ch2_range_flag, .ch1_paired_bits,
        .ch2_paired_bits, .ch1PairedComp, .ch2PairedComp, .shared_range_flag,
        .sharedRangeComp, .lvdsEnable, .lvdsDriveCode, .lvdsTermEnable
    );

    dao_rx_model rxModel (
        .ref_clk, .rst_n, .ddrMode, .clkP(fwd_data_clock_p),
        .ch1Full(ch1_sample_bits), .ch2Full(ch2_sample_bits),
        .ch1Flag(ch1_range_flag), .ch2Flag(ch2_range_flag),
        .ch1Lane(ch1_paired_bits), .ch2Lane(ch2_paired_bits),
        .sharedFlag(shared_range_flag), .rxValid, .rxWord, .rxLag
    );

    // ========================================================
    // Tasks
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        #1 d = regRdData;
    endtask

    task automatic waitFor(input int n, input bit forIrq);
        for (k = 0; forIrq ? irq !== 1'b1 : goodCnt < n; k++)
        begin
            @(posedge ref_clk);
            if (k > 3000)
            begin
                check("wait bound", 0, 1);
                end_sim();
            end
        end
    endtask

    // A new sample follows each encode rise and holds through capture.
    task automatic driveCodes();
        logic [31:0] r;
        logic prev;
        prev = 1'b0;
        forever
        begin
            @(posedge ref_clk);
            if (encode_clock_p && !prev)
            begin
                r = $urandom & 32'h1FFF1FFF;
                ch1ConvCode <= r[11:0];
                ch1ConvOver <= r[12];
                ch2ConvCode <= r[27:16];
                ch2ConvOver <= r[28];
                expQ.push_back(r);
            end
            prev = encode_clock_p;
        end
    endtask

    // ========================================================
    // Word model
    always @(posedge ref_clk)
    begin
        if (rxValid && !hold)
        begin
            idx = -1;
            foreach (expQ[i])
                if (idx < 0 && expQ[i] === rxWord)
                    idx = i;
            if (synced)
            begin
                front = expQ.size() > 0 ? expQ[0] : 0;
                check("word", rxWord, front);
                check("clock n", fwd_data_clock_n, !fwd_data_clock_p);
                lv = ~{ch1_paired_bits, ch2_paired_bits, shared_range_flag};
                lc = {ch1PairedComp, ch2PairedComp, sharedRangeComp};
                if (curFmt == 0)
                    check("lag", rxLag, curTaps);
                if (curFmt == 2)
                    check("comp", lc, lv);
            end
            if (idx >= 0)
            begin
                repeat (idx + 1) void'(expQ.pop_front());
                synced = 1'b1;
                goodCnt++;
            end
        end
    end

    // ========================================================
    // Main sequence
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial
    begin
        encode_clock_p = 1'b0;
        #5;
        forever #32 encode_clock_p = ~encode_clock_p;
    end

    initial
    begin
        {rst_n, regWrEn, regRdEn, encode_clock_n, config_method_strap} = 5'h0;
        {ch1ConvOver, ch2ConvOver, ch1ConvCode, ch2ConvCode} = 26'h0;
        {regAddr, regWrData, ddrMode, synced} = 42'h0;
        {error_cnt, n_tests, goodCnt, curFmt, curTaps} = 160'h0;
        hold = 1'b1;
        void'($urandom(32'h171790A1));
        fork
            driveCodes();
        join_none
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(8'h00, rdv);
        check("mode reset", rdv, 32'h00000040);
        wr(8'h14, 32'hFFFFFFFF);
        rd(8'h14, rdv);
        check("unmapped", rdv, 32'h00000000);
        rd(8'h10, rdv);
        check("info reset", rdv, 32'h00000000);
        for (int c = 0; c < 5; c++)
        begin
            mode = cfg[c];
            hold = 1'b1;
            wr(8'h00, mode);
            curFmt = mode[1:0];
            curTaps = mode[3:2];
            ddrMode = mode[1:0] != 2'h0;
            repeat (24) @(posedge ref_clk);
            #1 {synced, goodCnt, hold} = 34'h0;
            waitFor(6, 1'b0);
            rd(8'h00, rdv);
            check("mode", rdv, mode);
            rd(8'h10, rdv);
            check("format", rdv, {30'h0, mode[1:0]});
            check("lvds on", lvdsEnable, mode[1:0] == 2'h2);
            check("drive", lvdsDriveCode, mode[6:4]);
            check("term", lvdsTermEnable, mode[7] && curFmt == 2);
        end
        wr(8'h08, 32'h00000008);
        wr(8'h04, 32'h0000000F);
        repeat (2) @(posedge ref_clk);
        #1 check("irq masked", irq, 1'b0);
        wr(8'h00, 32'h00000003);
        repeat (2) @(posedge ref_clk);
        #1 check("irq refused", irq, 1'b1);
        rd(8'h10, rdv);
        check("format kept", rdv, 32'h00000002);
        wr(8'h04, 32'h00000008);
        repeat (2) @(posedge ref_clk);
        #1 check("irq cleared", irq, 1'b0);
        wr(8'h08, 32'h00000001);
        waitFor(0, 1'b1);
        check("irq sample", irq, 1'b1);
        wr(8'h08, 32'h00000000);
        config_method_strap <= 1'b1;
        repeat (8) @(posedge ref_clk);
        wr(8'h00, 32'h00000001);
        rd(8'h10, rdv);
        check("strap info", rdv, 32'h00000006);
        rd(8'h04, rdv);
        check("strap refused", rdv & 32'h00000008, 32'h00000008);
        end_sim();
    end
endmodule

`default_nettype wire
